/* File: verilog/iee_entry.sv */
// interrupt and exception entry sequencer with i/o address select
// assumes the core signals instruction and string-move boundaries, does the
// stack pushes it is asked for, and reads the gate words this block addresses
`timescale 1ns/1ps
`default_nettype none
`include "iee_defs.svh"
module iee_entry #(
  parameter int unsigned IO_ADDR_W = `IEE_IO_ADDR_W,
  parameter int unsigned MEM_ADDR_W = `IEE_MEM_ADDR_W
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // hardware request pins
  input wire logic maskable_request_input_i,
  input wire logic nmi_request_i,
  // core boundaries and requests
  input wire logic instr_boundary_i,
  input wire logic string_move_boundary_i,
  input wire iee_pkg::iee_xreq_t xreq_i,
  input wire logic interrupt_return_instr_i,
  input wire logic restored_if_i,
  input wire logic [MEM_ADDR_W-1:0] table_base_i,
  // core handshakes during entry
  input wire logic push_done_i,
  input wire logic gate_valid_i,
  input wire iee_pkg::iee_gate_t gate_type_i,
  // acknowledge cycle with the interrupt controller
  output logic ack_cycle_o,
  input wire logic ack_done_i,
  input wire logic [7:0] ack_vector_i,
  // entry sequence toward the core
  output logic push_req_o,
  output logic gate_fetch_o,
  output logic dispatch_valid_o,
  output iee_pkg::iee_dispatch_t dispatch_o,
  output logic if_flag_o,
  output logic nmi_active_o,
  output logic busy_o,
  // i/o access
  input wire iee_pkg::iee_ioreq_t ioreq_i,
  output logic mem_io_sel_o,
  output logic [MEM_ADDR_W-1:0] io_addr_o,
  output logic io_rsvd_o
);
  import iee_pkg::*;

  typedef enum logic [2:0] {
    IEE_ST_IDLE = 3'b000,
    IEE_ST_PUSH = 3'b001,
    IEE_ST_ACK = 3'b010,
    IEE_ST_FETCH = 3'b011,
    IEE_ST_DISP = 3'b100
  } iee_state_t;

  // source of the entry being handled
  typedef enum logic [1:0] {
    IEE_SRC_NMI = 2'b00,
    IEE_SRC_MASK = 2'b01,
    IEE_SRC_EXC = 2'b10
  } iee_src_t;

  iee_state_t state_q, state_d;
  iee_src_t src_q;
  iee_xclass_t xclass_q;
  logic [7:0] vec_q;
  logic [23:0] gate_addr_q;
  iee_gate_t gate_q;
  logic if_q;
  logic nmi_active_q;
  logic nmi_pend_q;
  logic nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic mreq_s1_q, mreq_s2_q;
  logic nmi_edge;
  logic window;
  logic take_nmi, take_mreq, take_exc;
  logic [MEM_ADDR_W-1:0] io_addr_d;

  // table address of a gate: base plus vector times entry size
  function automatic logic [MEM_ADDR_W-1:0] gate_addr_f(
    input logic [MEM_ADDR_W-1:0] base,
    input logic [7:0] vec
  );
    logic [MEM_ADDR_W-1:0] off;
    off = {{(MEM_ADDR_W-11){1'b0}}, vec, 3'h0};
    gate_addr_f = base + off;
  endfunction : gate_addr_f

  // pins come from outside the clock domain: two stages before use
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      mreq_s1_q <= 1'b0;
      mreq_s2_q <= 1'b0;
    end
    else
    begin
      nmi_s1_q <= nmi_request_i;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      mreq_s1_q <= maskable_request_input_i;
      mreq_s2_q <= mreq_s1_q;
    end
  end

  // nmi is edge-triggered so a held pin does not retrigger
  assign nmi_edge = nmi_s2_q & ~nmi_s3_q;

  // recognition points: instruction ends, plus string-move gaps
  assign window = instr_boundary_i | string_move_boundary_i;

  // arbitration, only from idle; exceptions belong to the running
  // instruction so they go ahead of external events
  always_comb
  begin
    take_exc = (state_q == IEE_ST_IDLE) & xreq_i.valid;
    take_nmi = (state_q == IEE_ST_IDLE) & ~xreq_i.valid & window
             & nmi_pend_q & ~nmi_active_q;
    take_mreq = (state_q == IEE_ST_IDLE) & ~xreq_i.valid & window
              & ~take_nmi & mreq_s2_q & if_q & ~nmi_active_q;
  end

  // pending nmi: set wins over clear, one arrival remembered
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      nmi_pend_q <= 1'b0;
    else if (nmi_edge)
      nmi_pend_q <= 1'b1;
    else if (take_nmi)
      nmi_pend_q <= 1'b0;
  end

  // nmi handler in progress until interrupt return
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      nmi_active_q <= 1'b0;
    else if (take_nmi)
      nmi_active_q <= 1'b1;
    else if (interrupt_return_instr_i)
      nmi_active_q <= 1'b0;
  end

  // interrupt-enable flag
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      if_q <= 1'b0;
    else if (state_q == IEE_ST_DISP && gate_q == IEE_GATE_IRQ)
      if_q <= 1'b0;
    else if (interrupt_return_instr_i)
      if_q <= restored_if_i;
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state_q <= IEE_ST_IDLE;
    else
      state_q <= state_d;
  end

  // entry sequence: push, vector, gate fetch, dispatch
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      IEE_ST_IDLE:
        if (take_exc | take_nmi | take_mreq)
          state_d = IEE_ST_PUSH;
      IEE_ST_PUSH:
        if (push_done_i)
        begin
          if (src_q == IEE_SRC_MASK)
            state_d = IEE_ST_ACK;
          else
            state_d = IEE_ST_FETCH;
        end
      IEE_ST_ACK:
        if (ack_done_i)
          state_d = IEE_ST_FETCH;
      IEE_ST_FETCH:
        if (gate_valid_i)
          state_d = IEE_ST_DISP;
      IEE_ST_DISP:
        state_d = IEE_ST_IDLE;
      default:
        state_d = IEE_ST_IDLE;
    endcase
  end

  // source and class captured at acceptance
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      src_q <= IEE_SRC_EXC;
      xclass_q <= IEE_XC_FAULT;
    end
    else if (take_exc)
    begin
      src_q <= IEE_SRC_EXC;
      xclass_q <= xreq_i.xclass;
    end
    else if (take_nmi)
    begin
      src_q <= IEE_SRC_NMI;
      xclass_q <= IEE_XC_TRAP; // resumes after the boundary
    end
    else if (take_mreq)
    begin
      src_q <= IEE_SRC_MASK;
      xclass_q <= IEE_XC_TRAP;
    end
  end

  // vector: internal for exceptions, fixed for nmi, bus for maskable
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      vec_q <= 8'h00;
    else if (take_exc)
      vec_q <= xreq_i.vector;
    else if (take_nmi)
      vec_q <= `IEE_VEC_NMI;
    else if (state_q == IEE_ST_ACK && ack_done_i)
      vec_q <= ack_vector_i;
  end

  // gate address, formed once the vector is known
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gate_addr_q <= `IEE_TABLE_BASE_RST;
    else if (state_d == IEE_ST_FETCH && state_q != IEE_ST_FETCH)
      gate_addr_q <= 24'(gate_addr_f(table_base_i,
                      (state_q == IEE_ST_ACK) ? ack_vector_i : vec_q));
  end

  // gate type as read from the table
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gate_q <= IEE_GATE_IRQ;
    else if (state_q == IEE_ST_FETCH && gate_valid_i)
      gate_q <= gate_type_i;
  end

  // dispatch record toward the core
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dispatch_valid_o <= 1'b0;
      dispatch_o <= '0;
    end
    else
    begin
      dispatch_valid_o <= (state_q == IEE_ST_DISP);
      if (state_q == IEE_ST_DISP)
      begin
        dispatch_o.vector <= vec_q;
        dispatch_o.gate_addr <= gate_addr_q;
        dispatch_o.resume_at_fault <= (xclass_q == IEE_XC_FAULT);
        dispatch_o.restartable <= (xclass_q != IEE_XC_ABORT);
        dispatch_o.to_task <= (gate_q == IEE_GATE_TASK);
      end
    end
  end

  // handshake strobes follow the state directly
  assign push_req_o = (state_q == IEE_ST_PUSH);
  assign ack_cycle_o = (state_q == IEE_ST_ACK);
  assign gate_fetch_o = (state_q == IEE_ST_FETCH);
  assign busy_o = (state_q != IEE_ST_IDLE);
  assign if_flag_o = if_q;
  assign nmi_active_o = nmi_active_q;

  // i/o port address: zero-extended, 8-bit immediate or 16-bit register
  always_comb
  begin
    io_addr_d = '0;
    if (ioreq_i.use_imm)
      io_addr_d[7:0] = ioreq_i.imm_port;
    else
      io_addr_d[IO_ADDR_W-1:0] = ioreq_i.port_reg[IO_ADDR_W-1:0];
  end

  // i/o bus outputs registered; select idles high for memory
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mem_io_sel_o <= 1'b1;
      io_addr_o <= '0;
      io_rsvd_o <= 1'b0;
    end
    else
    begin
      mem_io_sel_o <= ~ioreq_i.valid;
      if (ioreq_i.valid)
      begin
        io_addr_o <= io_addr_d;
        // flags touches of the range the system must leave free
        io_rsvd_o <= (io_addr_d[15:0] >= `IEE_IO_RSVD_LO)
                  && (io_addr_d[15:0] <= `IEE_IO_RSVD_HI);
      end
      else
        io_rsvd_o <= 1'b0;
    end
  end
endmodule : iee_entry
`default_nettype wire

/* File: verilog/iee_defs.svh */
// constants for the interrupt and exception entry block
// assumes inclusion by the package and the design file only
`ifndef IEE_DEFS_SVH
`define IEE_DEFS_SVH
`define IEE_IO_ADDR_W 16
`define IEE_MEM_ADDR_W 24
`define IEE_VEC_NMI 8'h02
`define IEE_VEC_RSVD_LAST 8'h1F
`define IEE_VEC_DOUBLE 8'h08
`define IEE_GATE_BYTES 8
`define IEE_GATE_SHIFT 3
`define IEE_IO_RSVD_LO 16'h00F8
`define IEE_IO_RSVD_HI 16'h00FF
`define IEE_TABLE_BASE_RST 24'h000000
`define IEE_PUSH_WORDS 3
`endif

/* File: verilog/iee_pkg.sv */
// types shared by the interrupt and exception entry block
// assumes the constants header sits beside it
`include "iee_defs.svh"
package iee_pkg;
  typedef enum logic [1:0] {
    IEE_XC_FAULT = 2'b00,
    IEE_XC_TRAP = 2'b01,
    IEE_XC_ABORT = 2'b10,
    IEE_XC_SOFT = 2'b11
  } iee_xclass_t;
  typedef enum logic [1:0] {
    IEE_GATE_IRQ = 2'b00,
    IEE_GATE_TRAP = 2'b01,
    IEE_GATE_TASK = 2'b10
  } iee_gate_t;
  // exception or software request from the core
  typedef struct packed {
    logic valid;
    iee_xclass_t xclass;
    logic [7:0] vector;
  } iee_xreq_t;
  // i/o access request from the execution unit
  typedef struct packed {
    logic valid;
    logic use_imm;
    logic wide;
    logic [7:0] imm_port;
    logic [15:0] port_reg;
  } iee_ioreq_t;
  // dispatch directions handed to the core
  typedef struct packed {
    logic [7:0] vector;
    logic [23:0] gate_addr;
    logic resume_at_fault;
    logic restartable;
    logic to_task;
  } iee_dispatch_t;
endpackage : iee_pkg

/* File: testbench/iee_entry_props.sv */
// checker for the interrupt and exception entry block
// assumes a bind onto the top module, seeing only its ports
`timescale 1ns/1ps
`default_nettype none
module iee_entry_props #(
  parameter int unsigned MEM_ADDR_W = 24
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // i/o side
  input wire iee_pkg::iee_ioreq_t ioreq_i,
  input wire logic mem_io_sel_o,
  input wire logic [MEM_ADDR_W-1:0] io_addr_o,
  input wire logic io_rsvd_o,
  // entry side
  input wire logic [MEM_ADDR_W-1:0] table_base_i,
  input wire logic push_req_o,
  input wire logic push_done_i,
  input wire logic ack_cycle_o,
  input wire logic gate_fetch_o,
  input wire logic gate_valid_i,
  input wire iee_pkg::iee_gate_t gate_type_i,
  input wire logic dispatch_valid_o,
  input wire iee_pkg::iee_dispatch_t dispatch_o,
  input wire logic if_flag_o
);
  import iee_pkg::*;
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  io_sel_a: assert property (mem_io_sel_o != $past(ioreq_i.valid))
    else $error("io select wrong");
  io_addr_a: assert property (ioreq_i.valid |=> io_addr_o == ($past(ioreq_i.use_imm) ?
    MEM_ADDR_W'($past(ioreq_i.imm_port)) : MEM_ADDR_W'($past(ioreq_i.port_reg))))
    else $error("io address wrong");
  io_rsvd_a: assert property (ioreq_i.valid |=>
    io_rsvd_o == (io_addr_o >= 16'h00F8 && io_addr_o <= 16'h00FF))
    else $error("reserved flag wrong");
  gate_addr_a: assert property (dispatch_valid_o |->
    dispatch_o.gate_addr == table_base_i + {dispatch_o.vector, 3'b000})
    else $error("gate address wrong");
  irq_gate_a: assert property (gate_fetch_o && gate_valid_i &&
    gate_type_i == IEE_GATE_IRQ |-> ##2 !if_flag_o)
    else $error("enable flag kept");
  trap_gate_a: assert property (gate_fetch_o && gate_valid_i &&
    gate_type_i == IEE_GATE_TRAP |-> ##2 if_flag_o == $past(if_flag_o, 2))
    else $error("enable flag changed");
  ack_order_a: assert property ($rose(ack_cycle_o) |-> $past(push_req_o && push_done_i))
    else $error("acknowledge before push");
  disp_time_a: assert property (gate_fetch_o && gate_valid_i |->
    !dispatch_valid_o ##2 dispatch_valid_o ##1 !dispatch_valid_o)
    else $error("dispatch timing wrong");
endmodule : iee_entry_props
`default_nettype wire

/* File: testbench/iee_pic_model.sv */
// behavioural interrupt controller behind the acknowledge cycle
// assumes the bench asks it to raise a request with a vector
`timescale 1ns/1ps
`default_nettype none
module iee_pic_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // bench commands
  input wire logic raise_i,
  input wire logic [7:0] vec_i,
  input wire logic slow_i,
  // acknowledge cycle
  input wire logic ack_cycle_i,
  output logic req_o,
  output logic ack_done_o,
  output logic [7:0] ack_vector_o
);
  logic [7:0] held_q;
  int wait_q;
  // request, then vector after a short or long wait
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      req_o <= 1'b0;
      ack_done_o <= 1'b0;
      ack_vector_o <= 8'h00;
      held_q <= 8'h00;
      wait_q <= 0;
    end
    else
    begin
      ack_done_o <= 1'b0;
      ack_vector_o <= ~ack_vector_o; // released bus never looks valid
      if (raise_i)
      begin
        req_o <= 1'b1;
        held_q <= vec_i;
      end
      if (ack_cycle_i && !ack_done_o)
      begin
        req_o <= 1'b0;
        wait_q <= wait_q + 1;
        if (wait_q >= (slow_i ? 3 : 0))
        begin
          ack_done_o <= 1'b1;
          ack_vector_o <= held_q;
          wait_q <= 0;
        end
      end
    end
  end
endmodule : iee_pic_model
`default_nettype wire

/* File: testbench/iee_entry_tb.sv */
// self-checking bench for the interrupt and exception entry block
// assumes the checker and the controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module iee_entry_tb;
  import iee_pkg::*;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, nmi_request_i = 1'b0, instr_boundary_i = 1'b0;
  logic string_move_boundary_i = 1'b0, interrupt_return_instr_i = 1'b0, restored_if_i = 1'b0;
  logic push_done_i = 1'b0, gate_valid_i = 1'b0, raise = 1'b0, slow = 1'b0;
  logic maskable_request_input_i, ack_cycle_o, ack_done_i, push_req_o, gate_fetch_o;
  logic dispatch_valid_o, if_flag_o, nmi_active_o, busy_o, mem_io_sel_o, io_rsvd_o;
  logic [7:0] pvec = 8'h00, ack_vector_i;
  logic [7:0] vx [4] = '{8'h00, 8'h01, 8'h08, 8'hFF};
  logic [23:0] table_base_i = 24'h012340, io_addr_o, a;
  iee_gate_t gate_type_i = IEE_GATE_IRQ;
  iee_xreq_t xreq_i = '0;
  iee_ioreq_t ioreq_i = '0;
  iee_dispatch_t dispatch_o;
  int failures = 0, cmp_count = 0, cyc = 0, acks = 0, seed = 32'h54139929;
  int exp_q[$];
  iee_entry uut (.ref_clk_i, .sys_rst_i, .maskable_request_input_i, .nmi_request_i,
    .instr_boundary_i, .string_move_boundary_i, .xreq_i, .interrupt_return_instr_i,
    .restored_if_i, .table_base_i, .push_done_i, .gate_valid_i, .gate_type_i, .ack_cycle_o,
    .ack_done_i, .ack_vector_i, .push_req_o, .gate_fetch_o, .dispatch_valid_o, .dispatch_o,
    .if_flag_o, .nmi_active_o, .busy_o, .ioreq_i, .mem_io_sel_o, .io_addr_o, .io_rsvd_o);
  iee_pic_model pic (.ref_clk_i, .sys_rst_i, .raise_i(raise), .vec_i(pvec), .slow_i(slow),
    .ack_cycle_i(ack_cycle_o), .req_o(maskable_request_input_i), .ack_done_o(ack_done_i),
    .ack_vector_o(ack_vector_i));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // cut a hang short
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // answer the core handshakes until a dispatch, then compare with the queue
  task automatic serve(input iee_gate_t g, input logic [1:0] bnd, input logic raf, rst);
    int n;
    logic [7:0] v;
    logic [34:0] ex;
    n = 0;
    while (dispatch_valid_o !== 1'b1 && n < 80)
    begin
      @(negedge ref_clk_i);
      if (busy_o) xreq_i.valid = 1'b0;
      push_done_i = push_req_o;
      gate_valid_i = gate_fetch_o;
      gate_type_i = g;
      instr_boundary_i = bnd[0] && n % 3 == 2;
      string_move_boundary_i = bnd[1] && n % 3 == 2;
      acks += int'(ack_cycle_o === 1'b1);
      n++;
    end
    instr_boundary_i = 1'b0;
    string_move_boundary_i = 1'b0;
    v = 8'(exp_q.pop_front());
    // a dispatch that never came must count, even if the old record matches
    chk("dispatch_valid", 1, dispatch_valid_o);
    ex = {v, table_base_i + {v, 3'b000}, raf, rst, g == IEE_GATE_TASK};
    chk("dispatch", ex, dispatch_o);
  endtask : serve
  task automatic do_return(input logic f);
    @(negedge ref_clk_i);
    interrupt_return_instr_i = 1'b1;
    restored_if_i = f;
    @(negedge ref_clk_i);
    interrupt_return_instr_i = 1'b0;
  endtask : do_return
  task automatic pic_raise(input logic [7:0] v, input logic s);
    @(negedge ref_clk_i);
    raise = 1'b1;
    pvec = v;
    slow = s;
    @(negedge ref_clk_i);
    raise = 1'b0;
  endtask : pic_raise
  // boundaries keep coming but nothing may start
  task automatic quiet(input int k);
    repeat (k)
    begin
      @(negedge ref_clk_i);
      instr_boundary_i = !instr_boundary_i;
      chk("busy", 0, busy_o);
    end
    instr_boundary_i = 1'b0;
  endtask : quiet
  initial
  begin
    repeat (2) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    // random ports, the low ones walked across the reserved range
    for (int i = 0; i < 40; i++)
    begin
      @(negedge ref_clk_i);
      ioreq_i = 27'($random(seed));
      ioreq_i.valid = 1'b1;
      if (i < 16)
      begin
        ioreq_i.imm_port = 8'hF2 + 8'(i);
        ioreq_i.port_reg = 16'h00F2 + 16'(i);
      end
      a = ioreq_i.use_imm ? 24'(ioreq_i.imm_port) : 24'(ioreq_i.port_reg);
      @(negedge ref_clk_i);
      chk("io_sel", 0, mem_io_sel_o);
      chk("io_addr", a, io_addr_o);
      chk("io_rsvd", a >= 24'h0000F8 && a <= 24'h0000FF, io_rsvd_o);
    end
    ioreq_i.valid = 1'b0;
    @(negedge ref_clk_i);
    chk("io_sel", 1, mem_io_sel_o);
    // masked request waits for the flag, then a slow acknowledge
    pic_raise(8'h20, 1'b1);
    quiet(12);
    do_return(1'b1);
    chk("if", 1, if_flag_o);
    exp_q.push_back(8'h20);
    serve(IEE_GATE_IRQ, 2'b10, 1'b0, 1'b1);
    chk("ack", 1, acks > 0);
    chk("if", 0, if_flag_o);
    do_return(1'b1);
    for (int c = 0; c < 4; c++)
    begin
      @(negedge ref_clk_i);
      xreq_i = '{1'b1, iee_xclass_t'(c), vx[c]};
      exp_q.push_back(vx[c]);
      serve(c == 3 ? IEE_GATE_TASK : IEE_GATE_TRAP, 2'b00, c == 0, c != 2);
      if (c < 3) chk("if", 1, if_flag_o);
    end
    // a return must restore a cleared flag image too, not only a set one
    do_return(1'b0);
    chk("if", 0, if_flag_o);
    // both pins at one boundary, a second edge held until the return
    do_return(1'b1);
    pic_raise(8'h41, 1'b0);
    nmi_request_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    acks = 0;
    exp_q.push_back(2);
    serve(IEE_GATE_TRAP, 2'b01, 1'b0, 1'b1);
    chk("nmi", 1, nmi_active_o);
    nmi_request_i = 1'b0;
    quiet(4);
    nmi_request_i = 1'b1;
    quiet(8);
    exp_q.push_back(2);
    do_return(1'b1);
    serve(IEE_GATE_TRAP, 2'b01, 1'b0, 1'b1);
    chk("ack", 0, acks);
    exp_q.push_back(8'h41);
    do_return(1'b1);
    serve(IEE_GATE_IRQ, 2'b01, 1'b0, 1'b1);
    chk("ack", 1, acks > 0);
    complete_run();
  end
endmodule : iee_entry_tb
bind iee_entry iee_entry_props #(.MEM_ADDR_W(MEM_ADDR_W)) props (.ref_clk_i, .sys_rst_i,
  .ioreq_i, .mem_io_sel_o, .io_addr_o, .io_rsvd_o, .table_base_i, .push_req_o, .push_done_i,
  .ack_cycle_o, .gate_fetch_o, .gate_valid_i, .gate_type_i, .dispatch_valid_o, .dispatch_o,
  .if_flag_o);
`default_nettype wire
